// file: core/iox_defines.svh
/*
 Register offsets, field positions, reset values and bus answer codes
 of the I/O and interrupt instruction execution block.
 Assumes inclusion by bare name from the core/ design files.
*/
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define IOX_OFF_CMD 8'h00
`define IOX_OFF_ACC 8'h04
`define IOX_OFF_REGB 8'h08
`define IOX_OFF_PTR 8'h0c
`define IOX_OFF_TSEL 8'h10
`define IOX_OFF_DEST 8'h14
`define IOX_OFF_PORTD 8'h18
`define IOX_OFF_STATUS 8'h1c
`define IOX_OFF_IRQ_STAT 8'h20
`define IOX_OFF_IRQ_CLR 8'h24
`define IOX_OFF_IRQ_EN 8'h28

// ==========================================================
// Field positions
`define IOX_TSEL_LVL_BIT 0
`define IOX_TSEL_FLAG_BIT 1
`define IOX_ST_ALLOW_BIT 0
`define IOX_ST_EXT_BIT 1
`define IOX_ST_SKIP_BIT 2
`define IOX_ST_PC_LSB 16
`define IOX_EVT_SKIP 0
`define IOX_EVT_EXT 1
`define IOX_EVT_BADCMD 2
`define IOX_NUM_EVT 3
`define IOX_PTR_MAX 4'h8

// ==========================================================
// Reset values
`define IOX_NIB_RST 4'h0
`define IOX_TSEL_RST 2'h0
`define IOX_PORTD_RST 9'h000
`define IOX_PC_RST 10'h000
`define IOX_EVT_RST 3'h0

// ==========================================================
// Bus answer codes
`define IOX_RESP_OKAY 2'h0
`define IOX_RESP_SLVERR 2'h2

`endif

// file: core/iox_pkg.sv
/*
 Types of the I/O and interrupt instruction execution block: command
 codes and the bus slave state encoding.
 Assumes compilation before every module of the block.
*/
package iox_pkg;

	// ==========================================================
	// Command codes written to the command register
	typedef enum logic [3:0] {
		IOX_CMD_NOP = 4'h0,
		IOX_CMD_TEST_BIT = 4'h1,
		IOX_CMD_OUT_WIDE = 4'h2,
		IOX_CMD_IN_WIDE = 4'h3,
		IOX_CMD_OUT_NIB = 4'h4,
		IOX_CMD_IN_NIB = 4'h5,
		IOX_CMD_IN_ANA = 4'h6,
		IOX_CMD_IRQ_ON = 4'h7,
		IOX_CMD_IRQ_OFF = 4'h8,
		IOX_CMD_TEST_IRQ = 4'h9,
		IOX_CMD_LOAD = 4'ha
	} iox_cmd_e;

	// ==========================================================
	// Bus channel states, one-hot
	typedef enum logic [2:0] {
		IOX_ST_IDLE = 3'h1,
		IOX_ST_EXEC = 3'h2,
		IOX_ST_RESP = 3'h4
	} iox_bus_st_e;

endpackage

// file: core/iox_axil_slave.sv
/*
 AXI4-Lite slave front end: takes write address and data in either
 order, one access per channel at a time, and hands a one-cycle write
 strobe and a read address to the register file.
 Assumes the register file answers wr_ok, rd_data and rd_ok combinationally.
*/
`timescale 1ns/1ps
`include "iox_defines.svh"

module iox_axil_slave #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register file side
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	import iox_pkg::*;

	iox_bus_st_e wst_reg, wst_next, rst_reg, rst_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0] wstrb_reg, wstrb_next;

	// ==========================================================
	// Write channel: ready drops on each handshake so order is free
	always_comb begin
		wst_next = wst_reg;
		awready_next = awready_reg;
		wready_next = wready_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		case (wst_reg)
			IOX_ST_IDLE: begin
				if (s_axi_awvalid && awready_reg) begin
					waddr_next = s_axi_awaddr;
					awready_next = 1'b0;
				end
				if (s_axi_wvalid && wready_reg) begin
					wdata_next = s_axi_wdata;
					wstrb_next = s_axi_wstrb;
					wready_next = 1'b0;
				end
				if (!awready_next && !wready_next) begin
					wst_next = IOX_ST_EXEC;
				end
			end
			IOX_ST_EXEC: begin
				bvalid_next = 1'b1;
				bresp_next = wr_ok ? `IOX_RESP_OKAY : `IOX_RESP_SLVERR;
				wst_next = IOX_ST_RESP;
			end
			IOX_ST_RESP: begin
				if (s_axi_bready) begin
					bvalid_next = 1'b0;
					awready_next = 1'b1;
					wready_next = 1'b1;
					wst_next = IOX_ST_IDLE;
				end
			end
			default: begin
				wst_next = IOX_ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Read channel: register file data captured in the exec cycle
	always_comb begin
		rst_next = rst_reg;
		arready_next = arready_reg;
		raddr_next = raddr_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rst_reg)
			IOX_ST_IDLE: begin
				if (s_axi_arvalid && arready_reg) begin
					raddr_next = s_axi_araddr;
					arready_next = 1'b0;
					rst_next = IOX_ST_EXEC;
				end
			end
			IOX_ST_EXEC: begin
				rvalid_next = 1'b1;
				rdata_next = rd_ok ? rd_data : 32'h0000_0000;
				rresp_next = rd_ok ? `IOX_RESP_OKAY : `IOX_RESP_SLVERR;
				rst_next = IOX_ST_RESP;
			end
			IOX_ST_RESP: begin
				if (s_axi_rready) begin
					rvalid_next = 1'b0;
					arready_next = 1'b1;
					rst_next = IOX_ST_IDLE;
				end
			end
			default: begin
				rst_next = IOX_ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_reg <= IOX_ST_IDLE;
			rst_reg <= IOX_ST_IDLE;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			arready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			bresp_reg <= `IOX_RESP_OKAY;
			rresp_reg <= `IOX_RESP_OKAY;
			waddr_reg <= '0;
			raddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			rdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			wst_reg <= wst_next;
			rst_reg <= rst_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			bresp_reg <= bresp_next;
			rresp_reg <= rresp_next;
			waddr_reg <= waddr_next;
			raddr_reg <= raddr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			wstrb_reg <= wstrb_next;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign wr_en = (wst_reg == IOX_ST_EXEC);
	assign wr_addr = waddr_reg;
	assign wr_data = wdata_reg;
	assign wr_strb = wstrb_reg;
	assign rd_addr = raddr_reg;
endmodule

// file: core/iox_irq_ctrl.sv
/*
 Sticky event status, write-one-to-clear, enable register and one
 level interrupt output.
 Assumes one-cycle event pulses and one-cycle register write strobes.
*/
`timescale 1ns/1ps
`include "iox_defines.svh"

module iox_irq_ctrl #(
	parameter int N = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Events and software access
	input wire logic [N-1:0] evt,
	input wire logic clr_wr,
	input wire logic en_wr,
	input wire logic [N-1:0] wr_bits,
	// State and interrupt
	output logic [N-1:0] stat,
	output logic [N-1:0] en,
	output logic irq
);
	logic [N-1:0] stat_reg, stat_next, en_reg, en_next;
	logic irq_reg, irq_next;

	// ==========================================================
	// Per bit: an event in the clear cycle still sets the bit
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_comb begin
				stat_next[i] = evt[i] | (stat_reg[i] & ~(clr_wr & wr_bits[i]));
			end
		end
	endgenerate

	// Enable and interrupt level
	always_comb begin
		en_next = en_wr ? wr_bits : en_reg;
		irq_next = |(stat_next & en_next);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_reg <= '0;
			en_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			en_reg <= en_next;
			irq_reg <= irq_next;
		end
	end

	assign stat = stat_reg;
	assign en = en_reg;
	assign irq = irq_reg;
endmodule

// file: core/iox_io_exec.sv
/*
 Execution of I/O and interrupt-control instructions of a 4-bit core,
 driven by command words written over AXI4-Lite.
 Assumes port inputs and the interrupt pin are synchronous to aclk.
*/
// Our own choices: the AXI4-Lite register port and the placing of the registers.
// Function
// - Test port D bit chosen by pointer (0..8); skip next when it is zero.
// - Wide output drives accumulator and register B onto the wide port.
// - Wide input captures wide port levels into the accumulator and register B.
// - Nibble output drives the accumulator onto the nibble port.
// - Nibble input captures nibble port levels into a core register.
// - Analog port input captures its digital levels into a core register.
// - Interrupt enable command sets the interrupt allow flag.
// - Interrupt disable command clears the interrupt allow flag.
// - With select bit 1 set, test the external event flag, then clear it.
// - With select bits both zero, test the interrupt pin for low level.
// - Load copies the accumulator to the destination, accumulator unchanged.
`timescale 1ns/1ps
`include "iox_defines.svh"

module iox_io_exec #(
	parameter int ADDR_W = 8,
	parameter int K_W = 4,
	parameter int D_W = 9
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Wide port
	input wire logic [7:0] port_s_in,
	output logic [7:0] port_s_out,
	output logic port_s_oe,
	// Nibble port
	input wire logic [3:0] port_f_in,
	output logic [3:0] port_f_out,
	output logic port_f_oe,
	// Analog-capable port and discrete outputs
	input wire logic [K_W-1:0] port_k_in,
	output logic [D_W-1:0] port_d_out,
	// Interrupt pin and request
	input wire logic int_pin_in,
	output logic irq
);
	import iox_pkg::*;

	logic wr_en, wr_ok, rd_ok, cmd_wr, exec, skip_hit, bad_cmd, ext_fall;
	logic ext_clr, clr_wr, en_wr;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data, mw, portd_merge;
	logic [3:0] wr_strb;
	logic [`IOX_NUM_EVT-1:0] evt, irq_stat, irq_en;
	iox_cmd_e cmd_code;

	logic [3:0] acc_reg, acc_next, regb_reg, regb_next, ptr_reg, ptr_next;
	logic [3:0] dest_reg, dest_next, cmd_reg, cmd_next;
	logic [1:0] tsel_reg, tsel_next;
	logic [D_W-1:0] portd_reg, portd_next;
	logic [7:0] ports_reg, ports_next;
	logic [3:0] portf_reg, portf_next;
	logic ports_oe_reg, ports_oe_next, portf_oe_reg, portf_oe_next;
	logic allow_reg, allow_next, ext_reg, ext_next, skip_reg, skip_next;
	logic int_prev_reg;
	logic [9:0] pc_reg, pc_next;

	// ==========================================================
	// Bus slave and interrupt block
	iox_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	iox_irq_ctrl #(.N(`IOX_NUM_EVT)) u_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.evt(evt),
		.clr_wr(clr_wr),
		.en_wr(en_wr),
		.wr_bits(mw[`IOX_NUM_EVT-1:0]),
		.stat(irq_stat),
		.en(irq_en),
		.irq(irq)
	);

	// ==========================================================
	// Byte-lane merge of write data over the old register value
	function automatic logic [31:0] iox_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Write strobes and decoded command
	always_comb begin
		mw = iox_merge(32'h0000_0000, wr_data, wr_strb);
		portd_merge = iox_merge({{(32-D_W){1'b0}}, portd_reg}, wr_data, wr_strb);
		cmd_wr = wr_en && (wr_addr == `IOX_OFF_CMD) && wr_strb[0];
		cmd_code = iox_cmd_e'(wr_data[3:0]);
		exec = cmd_wr && !skip_reg; // Suppressed word is not executed
		clr_wr = wr_en && (wr_addr == `IOX_OFF_IRQ_CLR);
		en_wr = wr_en && (wr_addr == `IOX_OFF_IRQ_EN) && wr_strb[0];
		ext_fall = int_prev_reg && !int_pin_in;
	end

	// ==========================================================
	// Register writes and command execution
	always_comb begin
		acc_next = acc_reg;
		regb_next = regb_reg;
		ptr_next = ptr_reg;
		dest_next = dest_reg;
		cmd_next = cmd_reg;
		tsel_next = tsel_reg;
		portd_next = portd_reg;
		ports_next = ports_reg;
		portf_next = portf_reg;
		ports_oe_next = ports_oe_reg;
		portf_oe_next = portf_oe_reg;
		allow_next = allow_reg;
		pc_next = pc_reg;
		skip_next = skip_reg;
		skip_hit = 1'b0;
		bad_cmd = 1'b0;
		ext_clr = 1'b0;
		if (wr_en && wr_strb[0]) begin
			case (wr_addr)
				`IOX_OFF_ACC: acc_next = wr_data[3:0];
				`IOX_OFF_REGB: regb_next = wr_data[3:0];
				`IOX_OFF_PTR: ptr_next = wr_data[3:0];
				`IOX_OFF_TSEL: tsel_next = wr_data[1:0];
				`IOX_OFF_DEST: dest_next = wr_data[3:0];
				default: ;
			endcase
		end
		if (wr_en && (wr_addr == `IOX_OFF_PORTD)) begin
			portd_next = portd_merge[D_W-1:0];
		end
		if (cmd_wr) begin
			cmd_next = wr_data[3:0];
			pc_next = pc_reg + 10'h001; // Suppressed word is stepped past too
			skip_next = 1'b0;
		end
		if (exec) begin
			case (cmd_code)
				IOX_CMD_NOP: ;
				IOX_CMD_TEST_BIT: begin
					// Pointer beyond 8 never skips
					if (ptr_reg <= `IOX_PTR_MAX) begin
						skip_hit = !portd_reg[ptr_reg];
					end
				end
				IOX_CMD_OUT_WIDE: begin
					ports_next = {regb_reg, acc_reg};
					ports_oe_next = 1'b1;
				end
				IOX_CMD_IN_WIDE: begin
					// Released so the pins show outside levels
					ports_oe_next = 1'b0;
					acc_next = port_s_in[3:0];
					regb_next = port_s_in[7:4];
				end
				IOX_CMD_OUT_NIB: begin
					portf_next = acc_reg;
					portf_oe_next = 1'b1;
				end
				IOX_CMD_IN_NIB: begin
					portf_oe_next = 1'b0;
					acc_next = port_f_in;
				end
				IOX_CMD_IN_ANA: begin
					acc_next = 4'(port_k_in);
				end
				IOX_CMD_IRQ_ON: allow_next = 1'b1;
				IOX_CMD_IRQ_OFF: allow_next = 1'b0;
				IOX_CMD_TEST_IRQ: begin
					if (tsel_reg[`IOX_TSEL_FLAG_BIT]) begin
						skip_hit = ext_reg;
						ext_clr = 1'b1;
					end else if (!tsel_reg[`IOX_TSEL_LVL_BIT]) begin
						skip_hit = !int_pin_in;
					end else begin
						skip_hit = int_pin_in;
					end
				end
				IOX_CMD_LOAD: dest_next = acc_reg;
				default: bad_cmd = 1'b1;
			endcase
			skip_next = skip_hit;
		end
	end

	// ==========================================================
	// External event flag: a new edge beats the test's clear
	always_comb begin
		ext_next = ext_fall | (ext_reg & ~ext_clr);
		evt = '0;
		evt[`IOX_EVT_SKIP] = exec & skip_hit;
		evt[`IOX_EVT_EXT] = ext_fall & allow_reg;
		evt[`IOX_EVT_BADCMD] = bad_cmd;
	end

	// ==========================================================
	// Register read mux and address decode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case (rd_addr)
			`IOX_OFF_CMD: rd_data[3:0] = cmd_reg;
			`IOX_OFF_ACC: rd_data[3:0] = acc_reg;
			`IOX_OFF_REGB: rd_data[3:0] = regb_reg;
			`IOX_OFF_PTR: rd_data[3:0] = ptr_reg;
			`IOX_OFF_TSEL: rd_data[1:0] = tsel_reg;
			`IOX_OFF_DEST: rd_data[3:0] = dest_reg;
			`IOX_OFF_PORTD: rd_data[D_W-1:0] = portd_reg;
			`IOX_OFF_STATUS: begin
				rd_data[`IOX_ST_ALLOW_BIT] = allow_reg;
				rd_data[`IOX_ST_EXT_BIT] = ext_reg;
				rd_data[`IOX_ST_SKIP_BIT] = skip_reg;
				rd_data[`IOX_ST_PC_LSB +: 10] = pc_reg;
			end
			`IOX_OFF_IRQ_STAT: rd_data[`IOX_NUM_EVT-1:0] = irq_stat;
			`IOX_OFF_IRQ_CLR: ;
			`IOX_OFF_IRQ_EN: rd_data[`IOX_NUM_EVT-1:0] = irq_en;
			default: rd_ok = 1'b0;
		endcase
	end

	// Writes to read-only registers are ignored but accepted
	always_comb begin
		case (wr_addr)
			`IOX_OFF_CMD, `IOX_OFF_ACC, `IOX_OFF_REGB, `IOX_OFF_PTR, `IOX_OFF_TSEL,
			`IOX_OFF_DEST, `IOX_OFF_PORTD, `IOX_OFF_STATUS, `IOX_OFF_IRQ_STAT,
			`IOX_OFF_IRQ_CLR, `IOX_OFF_IRQ_EN: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg <= `IOX_NIB_RST;
			regb_reg <= `IOX_NIB_RST;
			ptr_reg <= `IOX_NIB_RST;
			dest_reg <= `IOX_NIB_RST;
			cmd_reg <= `IOX_NIB_RST;
			tsel_reg <= `IOX_TSEL_RST;
			portd_reg <= `IOX_PORTD_RST;
			ports_reg <= 8'h00;
			portf_reg <= `IOX_NIB_RST;
			ports_oe_reg <= 1'b0;
			portf_oe_reg <= 1'b0;
			allow_reg <= 1'b0;
			ext_reg <= 1'b0;
			skip_reg <= 1'b0;
			int_prev_reg <= 1'b1;
			pc_reg <= `IOX_PC_RST;
		end else begin
			acc_reg <= acc_next;
			regb_reg <= regb_next;
			ptr_reg <= ptr_next;
			dest_reg <= dest_next;
			cmd_reg <= cmd_next;
			tsel_reg <= tsel_next;
			portd_reg <= portd_next;
			ports_reg <= ports_next;
			portf_reg <= portf_next;
			ports_oe_reg <= ports_oe_next;
			portf_oe_reg <= portf_oe_next;
			allow_reg <= allow_next;
			ext_reg <= ext_next;
			skip_reg <= skip_next;
			int_prev_reg <= int_pin_in;
			pc_reg <= pc_next;
		end
	end

	// ==========================================================
	// Pin outputs straight from registers
	assign port_s_out = ports_reg;
	assign port_s_oe = ports_oe_reg;
	assign port_f_out = portf_reg;
	assign port_f_oe = portf_oe_reg;
	assign port_d_out = portd_reg;
endmodule

// file: tb/iox_pins.sv
/*
 Board-side pin model for the wide and nibble ports.
 Assumes the bench sets board levels at rising clock edges.
*/
`timescale 1ns/1ps

module iox_pins (
	// Device drive
	input wire logic [7:0] s_out,
	input wire logic s_oe,
	input wire logic [3:0] f_out,
	input wire logic f_oe,
	// Board levels
	input wire logic [7:0] s_brd,
	input wire logic [3:0] f_brd,
	// Resolved pin levels
	output logic [7:0] s_pin,
	output logic [3:0] f_pin
);
	// ==========================================================
	// Pin resolution: a driving device beats the board's weak level
	assign s_pin = s_oe ? s_out : s_brd;
	assign f_pin = f_oe ? f_out : f_brd;
endmodule

// file: tb/iox_io_exec_sva.sv
/*
 Bus and port timing checker for the I/O execution block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module iox_io_exec_sva #(
	parameter int ADDR_W = 8,
	parameter int K_W = 4,
	parameter int D_W = 9
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Bus read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic [7:0] port_s_in,
	input wire logic [7:0] port_s_out,
	input wire logic port_s_oe,
	input wire logic [3:0] port_f_in,
	input wire logic [3:0] port_f_out,
	input wire logic port_f_oe,
	input wire logic [K_W-1:0] port_k_in,
	input wire logic [D_W-1:0] port_d_out,
	input wire logic int_pin_in,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Handshake steps
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// Answers come after exactly one busy cycle
	a_b_latency: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer off time");
	a_r_latency: assert property (ar_taken |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer off time");
	a_ar_drop: assert property (ar_taken |=> !s_axi_arready)
		else $error("second read accepted");
	a_b_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write channels not reopened");
	a_bad_read_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("refused read carries data");
	// Ports move only on a completed write, never spontaneously
	a_s_port_cause: assert property (!$stable(port_s_out) |-> $rose(s_axi_bvalid))
		else $error("wide port changed without command");
	a_f_port_cause: assert property (!$stable(port_f_out) |-> $rose(s_axi_bvalid))
		else $error("nibble port changed without command");
	a_d_port_cause: assert property (!$stable(port_d_out) |-> $rose(s_axi_bvalid))
		else $error("discrete port changed without write");
	a_irq_fall_cause: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
		else $error("interrupt dropped without write");
endmodule

bind iox_io_exec iox_io_exec_sva #(.ADDR_W(ADDR_W), .K_W(K_W), .D_W(D_W)) u_sva (.*);

// file: tb/iox_io_exec_tb.sv
/*
 Self-checking bench for the I/O and interrupt execution block.
 Assumes the design, package, pin model and checker are compiled first.
*/
`timescale 1ns/1ps

module iox_io_exec_tb;
	import iox_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, int_pin_in = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, port_s_in, port_s_out, s_brd = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, port_f_in, port_f_out, f_brd = 4'h0, port_k_in = 4'h0, fo, a, b;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic port_s_oe, port_f_oe, irq, sk, any_sk = 1'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [8:0] port_d_out, d;
	logic [33:0] exp_q[$];
	int err_total = 0, num_checks = 0, pc = 0;

	iox_io_exec uut (.*);
	iox_pins u_pins (.s_out(port_s_out), .s_oe(port_s_oe), .f_out(port_f_out), .f_oe(port_f_oe),
		.s_brd(s_brd), .f_brd(f_brd), .s_pin(port_s_in), .f_pin(port_f_in));

	// ==========================================================
	// Clock, shared tasks
	always #10 aclk = ~aclk;

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= adr;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				chk(s_axi_bresp, r);
				break;
			end
		end
	endtask

	task automatic cmd(input iox_cmd_e c);
		wr(8'h00, c);
		pc++;
	endtask

	// The expected word waits in the queue for the read watcher
	task automatic rd(input logic [7:0] adr, input logic [33:0] e);
		@(posedge aclk);
		exp_q.push_back(e);
		s_axi_araddr <= adr;
		s_axi_arvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		conclude();
	end

	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(32'haa351d5c));
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		chk({port_s_oe, port_f_oe, irq, port_d_out}, 12'h0);
		@(posedge aclk);
		s_brd <= $urandom;
		f_brd <= $urandom;
		port_k_in <= $urandom;
		cmd(IOX_CMD_IN_WIDE);
		rd(8'h04, s_brd[3:0]);
		rd(8'h08, s_brd[7:4]);
		cmd(IOX_CMD_IN_NIB);
		rd(8'h04, f_brd);
		cmd(IOX_CMD_IN_ANA);
		rd(8'h04, port_k_in);
		cmd(IOX_CMD_LOAD);
		rd(8'h14, port_k_in);
		rd(8'h04, port_k_in);
		$display("test inputs done");
		a = $urandom;
		b = $urandom;
		fo = a;
		wr(8'h04, a);
		wr(8'h08, b);
		cmd(IOX_CMD_OUT_WIDE);
		cmd(IOX_CMD_OUT_NIB);
		@(negedge aclk);
		chk({port_s_oe, port_s_out}, {1'h1, b, a});
		chk({port_f_oe, port_f_out}, {1'h1, a});
		cmd(IOX_CMD_IRQ_ON);
		rd(8'h1c, (pc << 16) | 1);
		cmd(IOX_CMD_IRQ_OFF);
		rd(8'h1c, pc << 16);
		$display("test outputs done");
		// Every pointer value plus one beyond the range, skip then a nibble write
		wr(8'h28, 32'h1);
		for (int y = 0; y < 10; y++) begin
			d = $urandom;
			d[0] = 1'h0;
			sk = (y < 9) && !d[y % 9];
			any_sk |= sk;
			wr(8'h18, d);
			wr(8'h0c, y);
			wr(8'h04, y);
			cmd(IOX_CMD_TEST_BIT);
			rd(8'h1c, (pc << 16) | (sk << 2));
			cmd(IOX_CMD_OUT_NIB);
			if (!sk) fo = 4'(y);
			@(negedge aclk);
			chk(port_f_out, fo);
			chk(port_d_out, d);
		end
		chk(irq, any_sk);
		wr(8'h28, 32'h0);
		@(negedge aclk);
		chk(irq, 1'h0);
		rd(8'h20, any_sk);
		wr(8'h24, 32'h7);
		wr(8'h00, 32'hb);
		pc++;
		rd(8'h20, 32'h4);
		wr(8'h40, 32'h0, 2'h2);
		rd(8'h40, 34'h200000000);
		$display("test skip done");
		cmd(IOX_CMD_IRQ_ON);
		wr(8'h10, 32'h2);
		wr(8'h28, 32'h2);
		@(posedge aclk);
		int_pin_in <= 1'h0;
		@(posedge aclk);
		int_pin_in <= 1'h1;
		rd(8'h1c, (pc << 16) | 3);
		@(negedge aclk);
		chk(irq, 1'h1);
		cmd(IOX_CMD_TEST_IRQ);
		rd(8'h1c, (pc << 16) | 5);
		cmd(IOX_CMD_NOP);
		wr(8'h24, 32'h2);
		@(negedge aclk);
		chk(irq, 1'h0);
		wr(8'h10, 32'h0);
		@(posedge aclk);
		int_pin_in <= 1'h0;
		cmd(IOX_CMD_TEST_IRQ);
		rd(8'h1c, (pc << 16) | 7);
		cmd(IOX_CMD_NOP);
		@(posedge aclk);
		int_pin_in <= 1'h1;
		cmd(IOX_CMD_TEST_IRQ);
		rd(8'h1c, (pc << 16) | 3);
		wr(8'h10, 32'h1);
		cmd(IOX_CMD_TEST_IRQ);
		rd(8'h1c, (pc << 16) | 7);
		$display("test interrupt done");
		conclude();
	end
endmodule
